// file: shared/usef_cfg.svh
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 32-bit classic Wishbone, word aligned registers
// Notes: definitions only
`ifndef USEF_CFG_SVH
`define USEF_CFG_SVH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define USEF_OFS_CTRL 8'h00
`define USEF_OFS_IFLS 8'h04
`define USEF_OFS_STAT 8'h08
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define USEF_CTRL_EN_BIT 0
`define USEF_CTRL_SIREN_BIT 1
`define USEF_CTRL_SIRLP_BIT 2
`define USEF_IFLS_TX_LSB 0
`define USEF_IFLS_RX_LSB 3
`define USEF_STAT_TXRUN_BIT 0
`define USEF_STAT_RXRUN_BIT 1
`define USEF_STAT_RXCNT_LSB 8
`define USEF_STAT_TXCNT_LSB 16
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define USEF_CTRL_RST 3'h0
`define USEF_IFLS_RST 6'h00
// ------------------------------------------------------------
// timing counts
// ------------------------------------------------------------
`define USEF_PULSE_TICKS 2'h3
`define USEF_BIT_TICKS 5'h10
`define USEF_DEPTH 16
`endif

// file: shared/usef_pkg.sv
// Purpose: types shared by the enable, infrared and trigger logic
// Assumes: nothing beyond the config header
// Notes: none
package usef_pkg;
   typedef struct packed {
      logic sir_lp;
      logic sir_en;
      logic uart_en;
   } usef_ctrl_type;

   typedef struct packed {
      logic [2:0] rx_trigger_level_sel;
      logic [2:0] tx_trigger_level_sel;
   } usef_ifls_type;

   typedef struct packed {
      logic [3:0] status;
      logic [7:0] char;
   } usef_rx_word_type;

   typedef enum logic [1:0] {
      USEF_ENC_IDLE = 2'b00,
      USEF_ENC_FULL = 2'b01,
      USEF_ENC_LP = 2'b10
   } usef_enc_state_type;
endpackage

// file: design/usef_core.sv
// Purpose: port enable, infrared encode/decode and FIFO trigger events
// Assumes: all inputs synchronous to clk_i; baud16 tick is one cycle wide
// Notes: FIFO contents live outside; only the fill counts are kept here
//
// Contract
// - with low-power select 0 a zero bit goes out as a high pulse of 3/16 bit period.
// - with low-power select 1 a zero bit goes out as a pulse of 3 low-power reference periods.
// - with infrared on, the infrared pins are used and the serial transmit line stays at one.
// - with infrared on, the serial receive line and modem inputs are ignored.
// - with infrared off, the infrared output stays low and the infrared input is ignored.
// - the global enable starts the port on the serial or infrared path.
// - clearing the global enable lets the current character finish first.
// - the receive trigger code 000 to 100 selects at least 1/8, 1/4, 1/2, 3/4 or 7/8 full.
// - each counted receive entry is one 12-bit word of character and status.
// - the transmit trigger code 000 to 100 selects at most 1/8, 1/4, 1/2, 3/4 or 7/8 full.
// - each counted transmit entry is one 8-bit word.
// - the FIFO events fire on crossing the threshold, not while beyond it.
`timescale 1ns/100ps
`default_nettype none
`include "usef_cfg.svh"

module usef_core
   import usef_pkg::*;
#(
   parameter int DEPTH = `USEF_DEPTH,
   parameter int CNT_W = $clog2(DEPTH) + 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // transmitter side and run control for both directions
   input wire logic baud16_tick_i,
   input wire logic tx_bit_start_i,
   input wire logic tx_serial_i,
   input wire logic tx_char_active_i,
   input wire logic rx_char_active_i,
   output logic tx_run_o,
   output logic rx_run_o,
   // fifo fill tracking
   input wire logic rx_push_i,
   input wire usef_rx_word_type rx_word_i,
   input wire logic rx_pop_i,
   input wire logic tx_push_i,
   input wire logic [7:0] tx_word_i,
   input wire logic tx_pop_i,
   output logic rx_fifo_irq_o,
   output logic tx_fifo_irq_o,
   // pins
   input wire logic ir_lowpower_ref_clock_i,
   input wire logic ir_rx_in_i,
   input wire logic rxd_i,
   input wire logic [3:0] modem_status_i,
   output logic ir_tx_pulse_out_o,
   output logic txd_o,
   output logic rx_serial_o,
   output logic [3:0] modem_status_o
);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   usef_ctrl_type ctrl_reg;
   usef_ifls_type ifls_reg;
   logic [CNT_W-1:0] rx_cnt_reg;
   logic [CNT_W-1:0] tx_cnt_reg;
   logic [CNT_W-1:0] rx_cnt_next;
   logic [CNT_W-1:0] tx_cnt_next;
   logic [CNT_W-1:0] rx_thr;
   logic [CNT_W-1:0] tx_thr;
   logic [31:0] rd_data;
   logic req;
   logic hit;

   function automatic logic [CNT_W-1:0] level_of(input logic [2:0] code);
      int eighths;
      case (code)
         3'h1: eighths = 2;
         3'h2: eighths = 4;
         3'h3: eighths = 6;
         3'h4: eighths = 7;
         default: eighths = 1;
      endcase
      return CNT_W'((DEPTH * eighths) / 8);
   endfunction

   // ------------------------------------------------------------
   // wishbone slave
   // ------------------------------------------------------------
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign hit = (wb_adr_i == `USEF_OFS_CTRL) || (wb_adr_i == `USEF_OFS_IFLS) ||
                (wb_adr_i == `USEF_OFS_STAT);

   always_comb begin
      rd_data = 32'h0000_0000;
      case (wb_adr_i)
         `USEF_OFS_CTRL: rd_data[2:0] = ctrl_reg;
         `USEF_OFS_IFLS: rd_data[5:0] = ifls_reg;
         `USEF_OFS_STAT: begin
            rd_data[`USEF_STAT_TXRUN_BIT] = tx_run_o;
            rd_data[`USEF_STAT_RXRUN_BIT] = rx_run_o;
            rd_data[`USEF_STAT_RXCNT_LSB +: CNT_W] = rx_cnt_reg;
            rd_data[`USEF_STAT_TXCNT_LSB +: CNT_W] = tx_cnt_reg;
         end
         default: rd_data = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req && hit;
         wb_err_o <= req && !hit;
         wb_dat_o <= (req && hit && !wb_we_i) ? rd_data : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= `USEF_CTRL_RST;
         ifls_reg <= `USEF_IFLS_RST;
      end else if (req && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i == `USEF_OFS_CTRL) begin
            ctrl_reg <= wb_dat_i[2:0];
         end
         if (wb_adr_i == `USEF_OFS_IFLS) begin
            ifls_reg <= wb_dat_i[5:0];
         end
      end
   end

   // ------------------------------------------------------------
   // port enable with character completion
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_run_o <= 1'b0;
         rx_run_o <= 1'b0;
      end else begin
         tx_run_o <= ctrl_reg.uart_en || (tx_run_o && tx_char_active_i);
         rx_run_o <= ctrl_reg.uart_en || (rx_run_o && rx_char_active_i);
      end
   end

   // ------------------------------------------------------------
   // fifo fill counts and crossing events
   // ------------------------------------------------------------
   always_comb begin
      rx_cnt_next = rx_cnt_reg;
      tx_cnt_next = tx_cnt_reg;
      // one 12-bit word per push
      if (rx_push_i && !rx_pop_i && rx_cnt_reg < CNT_W'(DEPTH)) begin
         rx_cnt_next = rx_cnt_reg + 1'b1;
      end else if (rx_pop_i && !rx_push_i && rx_cnt_reg != '0) begin
         rx_cnt_next = rx_cnt_reg - 1'b1;
      end
      // one 8-bit word per push
      if (tx_push_i && !tx_pop_i && tx_cnt_reg < CNT_W'(DEPTH)) begin
         tx_cnt_next = tx_cnt_reg + 1'b1;
      end else if (tx_pop_i && !tx_push_i && tx_cnt_reg != '0) begin
         tx_cnt_next = tx_cnt_reg - 1'b1;
      end
   end

   assign rx_thr = level_of(ifls_reg.rx_trigger_level_sel);
   assign tx_thr = level_of(ifls_reg.tx_trigger_level_sel);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_cnt_reg <= '0;
         tx_cnt_reg <= '0;
         rx_fifo_irq_o <= 1'b0;
         tx_fifo_irq_o <= 1'b0;
      end else begin
         rx_cnt_reg <= rx_cnt_next;
         tx_cnt_reg <= tx_cnt_next;
         rx_fifo_irq_o <= (rx_cnt_reg < rx_thr) && (rx_cnt_next >= rx_thr);
         tx_fifo_irq_o <= (tx_cnt_reg > tx_thr) && (tx_cnt_next <= tx_thr);
      end
   end

   // ------------------------------------------------------------
   // infrared encoder
   // ------------------------------------------------------------
   usef_enc_state_type enc_reg;
   usef_enc_state_type enc_next;
   logic [1:0] pcnt_reg;
   logic lp_ref_reg;
   logic lp_edge;
   logic ir_on;

   assign ir_on = ctrl_reg.sir_en && tx_run_o;
   assign lp_edge = ir_lowpower_ref_clock_i && !lp_ref_reg;

   always_comb begin
      enc_next = enc_reg;
      case (enc_reg)
         USEF_ENC_IDLE: begin
            if (ir_on && tx_bit_start_i && !tx_serial_i) begin
               enc_next = ctrl_reg.sir_lp ? USEF_ENC_LP : USEF_ENC_FULL;
            end
         end
         USEF_ENC_FULL: begin
            if (baud16_tick_i && pcnt_reg == `USEF_PULSE_TICKS - 2'h1) begin
               enc_next = USEF_ENC_IDLE;
            end
         end
         USEF_ENC_LP: begin
            if (lp_edge && pcnt_reg == `USEF_PULSE_TICKS - 2'h1) begin
               enc_next = USEF_ENC_IDLE;
            end
         end
         default: enc_next = USEF_ENC_IDLE;
      endcase
      if (!ctrl_reg.sir_en) begin
         enc_next = USEF_ENC_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enc_reg <= USEF_ENC_IDLE;
         pcnt_reg <= 2'h0;
         lp_ref_reg <= 1'b0;
         ir_tx_pulse_out_o <= 1'b0;
      end else begin
         enc_reg <= enc_next;
         lp_ref_reg <= ir_lowpower_ref_clock_i;
         if (enc_next == USEF_ENC_IDLE || enc_reg == USEF_ENC_IDLE) begin
            pcnt_reg <= 2'h0;
         end else if ((enc_reg == USEF_ENC_FULL && baud16_tick_i) ||
                      (enc_reg == USEF_ENC_LP && lp_edge)) begin
            pcnt_reg <= pcnt_reg + 2'h1;
         end
         ir_tx_pulse_out_o <= enc_next != USEF_ENC_IDLE;
      end
   end

   // ------------------------------------------------------------
   // serial line muxing and infrared decoder
   // ------------------------------------------------------------
   logic [4:0] dec_cnt_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         txd_o <= 1'b1;
         dec_cnt_reg <= 5'h00;
         rx_serial_o <= 1'b1;
         modem_status_o <= 4'h0;
      end else begin
         txd_o <= ctrl_reg.sir_en ? 1'b1 : tx_serial_i;
         // stretch each received light pulse to one low bit
         if (!ctrl_reg.sir_en) begin
            dec_cnt_reg <= 5'h00;
         end else if (ir_rx_in_i) begin
            dec_cnt_reg <= `USEF_BIT_TICKS;
         end else if (baud16_tick_i && dec_cnt_reg != 5'h00) begin
            dec_cnt_reg <= dec_cnt_reg - 5'h01;
         end
         if (ctrl_reg.sir_en) begin
            rx_serial_o <= !(ir_rx_in_i || dec_cnt_reg != 5'h00);
         end else begin
            rx_serial_o <= rxd_i;
         end
         if (!ctrl_reg.sir_en) begin
            modem_status_o <= modem_status_i;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_full_width;
      @(posedge clk_i) disable iff (rst_i)
      enc_reg == USEF_ENC_FULL && baud16_tick_i && pcnt_reg == 2'h2 |=> !ir_tx_pulse_out_o;
   endproperty
   a_full_width: assert property (p_full_width) else $error("short pulse too long");

   property p_lp_width;
      @(posedge clk_i) disable iff (rst_i)
      enc_reg == USEF_ENC_LP && ctrl_reg.sir_en && !(lp_edge && pcnt_reg == 2'h2)
         |=> ir_tx_pulse_out_o;
   endproperty
   a_lp_width: assert property (p_lp_width) else $error("low power pulse ended early");

   property p_txd_mark;
      @(posedge clk_i) disable iff (rst_i)
      ctrl_reg.sir_en |=> txd_o;
   endproperty
   a_txd_mark: assert property (p_txd_mark) else $error("transmit line left mark");

   property p_modem_freeze;
      @(posedge clk_i) disable iff (rst_i)
      ctrl_reg.sir_en && $past(ctrl_reg.sir_en) |=> $stable(modem_status_o);
   endproperty
   a_modem_freeze: assert property (p_modem_freeze) else $error("modem input not ignored");

   property p_ir_off;
      @(posedge clk_i) disable iff (rst_i)
      !ctrl_reg.sir_en |=> !ir_tx_pulse_out_o;
   endproperty
   a_ir_off: assert property (p_ir_off) else $error("light pulse while infrared off");

   property p_run_hold;
      @(posedge clk_i) disable iff (rst_i)
      tx_run_o && tx_char_active_i |=> tx_run_o;
   endproperty
   a_run_hold: assert property (p_run_hold) else $error("stopped mid character");

   property p_run_start;
      @(posedge clk_i) disable iff (rst_i)
      ctrl_reg.uart_en |=> tx_run_o && rx_run_o;
   endproperty
   a_run_start: assert property (p_run_start) else $error("port not started");

   property p_rx_cross;
      @(posedge clk_i) disable iff (rst_i)
      rx_fifo_irq_o |-> rx_cnt_reg >= $past(rx_thr) && $past(rx_cnt_reg) < $past(rx_thr);
   endproperty
   a_rx_cross: assert property (p_rx_cross) else $error("receive event without crossing");

   property p_tx_cross;
      @(posedge clk_i) disable iff (rst_i)
      tx_fifo_irq_o |-> tx_cnt_reg <= $past(tx_thr) && $past(tx_cnt_reg) > $past(tx_thr);
   endproperty
   a_tx_cross: assert property (p_tx_cross) else $error("transmit event without crossing");

   property p_ifls_reset;
      @(posedge clk_i)
      rst_i |=> ifls_reg == 6'h00;
   endproperty
   a_ifls_reset: assert property (p_ifls_reset) else $error("trigger fields not cleared");

endmodule
`default_nettype wire

// file: testbench/usef_far_end.sv
// Purpose: far-end infrared transceiver and serial line model
// Assumes: bench clock; light and line levels commanded by the bench
// Notes: low-power reference runs free, period 8 cycles
`timescale 1ns/100ps
`default_nettype none
module usef_far_end (
   // control from bench
   input wire logic clk_i,
   input wire logic light_i,
   input wire logic mark_i,
   input wire logic [3:0] modem_i,
   // lines into the port
   output logic ir_rx_in_o,
   output logic rxd_o,
   output logic [3:0] modem_o,
   output logic lp_ref_o
);
   logic [2:0] lp_cnt_reg = 3'h0;

   // free-running reference, no reset on the far side
   always @(posedge clk_i) begin
      lp_cnt_reg <= lp_cnt_reg + 3'h1;
   end

   assign lp_ref_o = lp_cnt_reg[2];
   assign ir_rx_in_o = light_i;
   assign rxd_o = mark_i;
   assign modem_o = modem_i;
endmodule
`default_nettype wire

// file: testbench/usef_tb_top.sv
// Purpose: self-checking bench for usef_core
// Assumes: DEPTH 16, baud16 tick every second cycle
// Notes: wishbone master accepts ack or err as the answer
`timescale 1ns/100ps
`default_nettype none
`include "usef_cfg.svh"
module usef_tb_top;
   import usef_pkg::*;
   localparam int DEPTH = `USEF_DEPTH;
   int mul[5] = '{1, 2, 4, 6, 7};
   int n_fail = 0, cmp_count = 0;
   logic clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0, ack, err;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h1, modem_cmd = 4'h0, modem_in, modem_out;
   logic [31:0] dat = 32'h0000_0000, q_dat;
   logic tick = 1'b0, bit_start = 1'b0, tx_ser = 1'b1, tx_act = 1'b0, rx_act = 1'b0;
   logic rx_push = 1'b0, rx_pop = 1'b0, tx_push = 1'b0, tx_pop = 1'b0;
   logic light = 1'b0, mark = 1'b1, tx_run, rx_run, rx_irq, tx_irq;
   logic lp_ref, ir_in, rxd, ir_out, txd, rx_ser;
   usef_rx_word_type rx_word = 12'h0a5;

   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) tick <= ~tick;

   usef_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q_dat),
      .wb_ack_o(ack), .wb_err_o(err), .baud16_tick_i(tick), .tx_bit_start_i(bit_start),
      .tx_serial_i(tx_ser), .tx_char_active_i(tx_act), .rx_char_active_i(rx_act),
      .tx_run_o(tx_run), .rx_run_o(rx_run), .rx_push_i(rx_push), .rx_word_i(rx_word),
      .rx_pop_i(rx_pop), .tx_push_i(tx_push), .tx_word_i(8'h5a), .tx_pop_i(tx_pop),
      .rx_fifo_irq_o(rx_irq), .tx_fifo_irq_o(tx_irq), .ir_lowpower_ref_clock_i(lp_ref),
      .ir_rx_in_i(ir_in), .rxd_i(rxd), .modem_status_i(modem_in),
      .ir_tx_pulse_out_o(ir_out), .txd_o(txd), .rx_serial_o(rx_ser),
      .modem_status_o(modem_out));
   usef_far_end i_far (.clk_i(clk_i), .light_i(light), .mark_i(mark), .modem_i(modem_cmd),
      .ir_rx_in_o(ir_in), .rxd_o(rxd), .modem_o(modem_in), .lp_ref_o(lp_ref));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
      int i;
      @(posedge clk_i);
      req <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (ack === 1'b1 || err === 1'b1) break;
      end
      if (i == 20) begin
         n_fail++;
         stop_test();
      end
      q = q_dat;
      e = err;
      req <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      wb(1'b1, a, d, q, e);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic ex_err);
      logic [31:0] q;
      logic e;
      wb(1'b0, a, 32'h0000_0000, q, e);
      chk(q, exp);
      chk({31'h0, e}, {31'h0, ex_err});
   endtask

   task automatic fop(input int k, output logic [1:0] irq);
      @(posedge clk_i);
      case (k)
         0: rx_push <= 1'b1;
         1: rx_pop <= 1'b1;
         2: tx_push <= 1'b1;
         default: tx_pop <= 1'b1;
      endcase
      @(posedge clk_i);
      {rx_push, rx_pop, tx_push, tx_pop} <= 4'h0;
      @(posedge clk_i);
      irq = {rx_irq, tx_irq};
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_fifo(input int c);
      int t, n;
      logic [1:0] q;
      t = DEPTH * mul[c] / 8;
      wr(`USEF_OFS_IFLS, 32'(c * 9));
      rdc(`USEF_OFS_IFLS, 32'(c * 9), 1'b0);
      for (n = 1; n <= t + 1; n++) begin
         fop(0, q);
         chk({30'h0, q}, {30'h0, n == t, 1'b0});
      end
      rdc(`USEF_OFS_STAT, 32'(t + 1) << `USEF_STAT_RXCNT_LSB, 1'b0);
      for (n = t; n >= 0; n--) begin
         fop(1, q);
         chk({30'h0, q}, 32'h0000_0000);
      end
      for (n = 1; n <= DEPTH; n++) begin
         fop(2, q);
         chk({30'h0, q}, 32'h0000_0000);
      end
      rdc(`USEF_OFS_STAT, 32'(DEPTH) << `USEF_STAT_TXCNT_LSB, 1'b0);
      for (n = DEPTH - 1; n >= 0; n--) begin
         fop(3, q);
         chk({30'h0, q}, {31'h0, n == t});
      end
   endtask

   task automatic t_run();
      wr(`USEF_OFS_CTRL, 32'h0000_0001);
      @(posedge clk_i);
      chk({30'h0, tx_run, rx_run}, 32'h0000_0003);
      rdc(`USEF_OFS_STAT, 32'h0000_0003, 1'b0);
      tx_act <= 1'b1;
      rx_act <= 1'b1;
      wr(`USEF_OFS_CTRL, 32'h0000_0000);
      repeat (3) @(posedge clk_i);
      chk({30'h0, tx_run, rx_run}, 32'h0000_0003);
      tx_act <= 1'b0;
      rx_act <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk({30'h0, tx_run, rx_run}, 32'h0000_0000);
   endtask

   task automatic t_ir(input logic lp, input int lo, input int hi);
      int n;
      wr(`USEF_OFS_CTRL, {29'h0, lp, 2'b11});
      tx_ser <= 1'b0;
      bit_start <= 1'b1;
      @(posedge clk_i);
      bit_start <= 1'b0;
      n = 0;
      repeat (60) begin
         @(posedge clk_i);
         n += (ir_out === 1'b1) ? 1 : 0;
      end
      chk({31'h0, n >= lo && n <= hi}, 32'h0000_0001);
      chk({31'h0, txd}, 32'h0000_0001);
      tx_ser <= 1'b1;
   endtask

   task automatic t_rxpath();
      logic [3:0] m;
      wr(`USEF_OFS_CTRL, 32'h0000_0003);
      m = modem_out;
      mark <= 1'b0;
      modem_cmd <= ~m;
      repeat (40) @(posedge clk_i);
      chk({31'h0, rx_ser}, 32'h0000_0001);
      chk({28'h0, modem_out}, {28'h0, m});
      light <= 1'b1;
      repeat (2) @(posedge clk_i);
      light <= 1'b0;
      @(posedge clk_i);
      chk({31'h0, rx_ser}, 32'h0000_0000);
      wr(`USEF_OFS_CTRL, 32'h0000_0001);
      light <= 1'b1;
      tx_ser <= 1'b0;
      bit_start <= 1'b1;
      @(posedge clk_i);
      bit_start <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk({30'h0, rx_ser, ir_out}, 32'h0000_0000);
      chk({31'h0, txd}, 32'h0000_0000);
      mark <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk({30'h0, rx_ser, ir_out}, 32'h0000_0002);
      light <= 1'b0;
      tx_ser <= 1'b1;
   endtask

   task automatic t_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(`USEF_OFS_IFLS, 32'h0000_0000, 1'b0);
      chk({30'h0, tx_run, rx_run}, 32'h0000_0000);
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(`USEF_OFS_CTRL, 32'h0000_0000, 1'b0);
      rdc(`USEF_OFS_IFLS, 32'h0000_0000, 1'b0);
      rdc(8'h40, 32'h0000_0000, 1'b1);
      for (int c = 0; c < 5; c++) t_fifo(c);
      t_run();
      t_ir(1'b0, 4, 7);
      t_ir(1'b1, 16, 27);
      t_rxpath();
      t_reset();
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      stop_test();
   end
endmodule
`default_nettype wire
